/* File: rtl/mmd_pkg.sv */
package mmd_pkg;
	localparam int MMD_ADDR_W = 24;
	localparam int MMD_NORM_ADDR_W = 16;
	localparam int MMD_AREA_W = 3;
	localparam int MMD_MODE_W = 4;
	localparam int MMD_SYNC_STAGES = 2;

	// operating mode codes as strapped on the mode pins
	localparam logic [3:0] MMD_MODE_1 = 4'h1;
	localparam logic [3:0] MMD_MODE_2 = 4'h2;
	localparam logic [3:0] MMD_MODE_3 = 4'h3;
	localparam logic [3:0] MMD_MODE_4 = 4'h4;
	localparam logic [3:0] MMD_MODE_5 = 4'h5;
	localparam logic [3:0] MMD_MODE_6 = 4'h6;
	localparam logic [3:0] MMD_MODE_7 = 4'h7;
	localparam logic [3:0] MMD_MODE_10 = 4'ha;
	localparam logic [3:0] MMD_MODE_11 = 4'hb;
	localparam logic [3:0] MMD_MODE_14 = 4'he;
	localparam logic [3:0] MMD_MODE_15 = 4'hf;

	// fixed layout of the top 64 kbytes (low 16 bits of the address)
	localparam logic [15:0] MMD_ROM_NORM_END = 16'hdfff;
	localparam logic [15:0] MMD_RSV_BASE = 16'hec00;
	localparam logic [15:0] MMD_RAM_BASE = 16'hf400;
	localparam logic [15:0] MMD_EXT_MID_BASE = 16'hfc00;
	localparam logic [15:0] MMD_IO_LO_BASE = 16'hfe40;
	localparam logic [15:0] MMD_EXT_HI_BASE = 16'hff08;
	localparam logic [15:0] MMD_IO_HI_BASE = 16'hff28;
	localparam logic [7:0] MMD_ADV_TOP_PAGE = 8'hff;

	// last on-chip rom byte per variant size
	localparam logic [23:0] MMD_ROM_64K_END = 24'h00ffff;
	localparam logic [23:0] MMD_ROM_96K_END = 24'h017fff;
	localparam logic [23:0] MMD_ROM_128K_END = 24'h01ffff;

	typedef enum logic [1:0] {
		MMD_VAR_LARGE = 2'h0,
		MMD_VAR_MID = 2'h1,
		MMD_VAR_SMALL = 2'h3,
		MMD_VAR_SPARE = 2'h2
	} mmd_variant_e;

	typedef struct packed {
		logic rom;
		logic ram;
		logic io;
		logic ext;
		logic rsv;
	} mmd_sel_s;

	typedef struct packed {
		logic valid;
		logic [MMD_ADDR_W-1:0] addr;
	} mmd_req_s;

	typedef struct packed {
		logic valid;
		logic [MMD_ADDR_W-1:0] addr;
		mmd_sel_s sel;
		logic [MMD_AREA_W-1:0] area;
		logic area_valid;
	} mmd_ans_s;
endpackage : mmd_pkg

/* File: rtl/mmd_pin_sync.sv */
`timescale 1ns/1ps
module mmd_pin_sync #(
	parameter int W = 6,
	parameter int STAGES = 2
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import mmd_pkg::*;

	// straps come from pins; only the last stage is ever read
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic [STAGES-1:0] chain;
			logic [STAGES-1:0] next_chain;
			always_comb begin
				next_chain = {chain[STAGES-2:0], d[i]};
			end
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					chain <= '0;
				end else begin
					chain <= next_chain;
				end
			end
			assign q[i] = chain[STAGES-1];
		end
	endgenerate
endmodule : mmd_pin_sync

/* File: rtl/mmd_map_decoder.sv */
// What this block does
// - modes one to three decode a 16-bit, 64-kbyte address space
// - advanced modes four-seven, ten, eleven, fourteen, fifteen decode 24-bit, 16 Mbytes
// - on-chip rom is 128, 96 or 64 kbytes by variant; the spare strap has none
// - normal modes two and three map at most 56 kbytes of rom
// - modes four-six, ten, fourteen report which of eight areas is hit
// - largest variant upper rom: reserved when extension bit set, rom when clear
// - middle variant upper rom: external (reserved in single-chip) when extension bit set, rom when clear
// - above middle variant rom: external when extension bit set in expanded modes, reserved otherwise
// - expanded modes with ram enable clear send ram range external
// - single-chip modes enable rom and never map external space
// - mode one disables rom, low range external, 8-bit bus
`timescale 1ns/1ps
module mmd_map_decoder (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [mmd_pkg::MMD_MODE_W-1:0] mode_pin,
	input wire logic [1:0] variant_pin,
	input wire mmd_pkg::mmd_req_s req,
	input wire logic rom_extension_select,
	input wire logic ram_enable_bit,
	output mmd_pkg::mmd_ans_s ans,
	output logic bus8_mode,
	output logic mode_bad
);
	import mmd_pkg::*;

	logic [MMD_MODE_W+1:0] pins_s;
	logic [MMD_MODE_W-1:0] mode_s;
	mmd_variant_e variant_s;
	logic normal;
	logic adv;
	logic single;
	logic rom_on;
	logic area_mode;
	logic top;
	logic [MMD_ADDR_W-1:0] a;
	logic [15:0] lo;
	mmd_sel_s sel;
	mmd_ans_s next_ans;
	logic next_bus8_mode;
	logic next_mode_bad;

	// straps cross from pins; logic reads only the synced copy
	mmd_pin_sync #(
		.W(MMD_MODE_W + 2),
		.STAGES(MMD_SYNC_STAGES)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.d({mode_pin, variant_pin}),
		.q(pins_s)
	);

	assign mode_s = pins_s[MMD_MODE_W+1:2];
	assign variant_s = mmd_variant_e'(pins_s[1:0]);

	always_comb begin
		normal = mode_s inside {MMD_MODE_1, MMD_MODE_2, MMD_MODE_3};
		adv = mode_s inside {MMD_MODE_4, MMD_MODE_5, MMD_MODE_6, MMD_MODE_7,
			MMD_MODE_10, MMD_MODE_11, MMD_MODE_14, MMD_MODE_15};
		single = mode_s inside {MMD_MODE_3, MMD_MODE_7, MMD_MODE_11,
			MMD_MODE_15};
		rom_on = mode_s inside {MMD_MODE_2, MMD_MODE_3, MMD_MODE_6,
			MMD_MODE_7, MMD_MODE_10, MMD_MODE_11, MMD_MODE_14, MMD_MODE_15};
		area_mode = mode_s inside {MMD_MODE_4, MMD_MODE_5, MMD_MODE_6,
			MMD_MODE_10, MMD_MODE_14};
		// normal modes ignore the upper byte entirely
		a = normal ? {8'h00, req.addr[15:0]} : req.addr;
		lo = a[15:0];
		top = normal || (a[23:16] == MMD_ADV_TOP_PAGE);
		sel = '0;
		if (!normal && !adv) begin
			sel.rsv = 1'b1;
		end else if (top && lo >= MMD_IO_HI_BASE) begin
			sel.io = 1'b1;
		end else if (top && lo >= MMD_EXT_HI_BASE) begin
			sel.ext = !single;
			sel.rsv = single;
		end else if (top && lo >= MMD_IO_LO_BASE) begin
			sel.io = 1'b1;
		end else if (top && lo >= MMD_EXT_MID_BASE) begin
			sel.ext = !single;
			sel.rsv = single;
		end else if (top && lo >= MMD_RAM_BASE) begin
			// single-chip has no bus, so a disabled ram reads as reserved
			sel.ram = ram_enable_bit;
			sel.ext = !ram_enable_bit && !single;
			sel.rsv = !ram_enable_bit && single;
		end else if (top && lo >= MMD_RSV_BASE) begin
			sel.rsv = 1'b1;
		end else if (normal) begin
			if (rom_on && lo <= MMD_ROM_NORM_END) begin
				// spare strap has no rom fitted, so the range reads reserved
				sel.rom = variant_s != MMD_VAR_SPARE;
				sel.rsv = variant_s == MMD_VAR_SPARE;
			end else begin
				sel.ext = !single;
				sel.rsv = single;
			end
		end else if (rom_on && a <= MMD_ROM_64K_END) begin
			sel.rom = variant_s != MMD_VAR_SPARE;
			sel.rsv = variant_s == MMD_VAR_SPARE;
		end else if (rom_on && variant_s == MMD_VAR_LARGE &&
			a <= MMD_ROM_128K_END) begin
			sel.rom = !rom_extension_select;
			sel.rsv = rom_extension_select;
		end else if (rom_on && variant_s == MMD_VAR_MID &&
			a <= MMD_ROM_96K_END) begin
			sel.rom = !rom_extension_select;
			sel.ext = rom_extension_select && !single;
			sel.rsv = rom_extension_select && single;
		end else if (rom_on && variant_s == MMD_VAR_MID &&
			a <= MMD_ROM_128K_END) begin
			sel.ext = rom_extension_select && !single;
			sel.rsv = !rom_extension_select || single;
		end else begin
			sel.ext = !single;
			sel.rsv = single;
		end
		next_ans = '0;
		if (req.valid) begin
			next_ans.valid = 1'b1;
			next_ans.addr = a;
			// reserved hits carry only the rsv flag, no select
			next_ans.sel = sel;
			next_ans.area = a[23:21];
			next_ans.area_valid = area_mode;
		end
		next_bus8_mode = mode_s inside {MMD_MODE_1, MMD_MODE_2};
		next_mode_bad = !normal && !adv;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ans <= '0;
			bus8_mode <= 1'b0;
			mode_bad <= 1'b0;
		end else begin
			ans <= next_ans;
			bus8_mode <= next_bus8_mode;
			mode_bad <= next_mode_bad;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	AST_NORM_16BIT: assert property (
		req.valid && normal |=> ans.valid && ans.addr[23:16] == 8'h00 &&
			ans.addr[15:0] == $past(req.addr[15:0]))
	else $error("normal mode address not cut to 16 bits");

	AST_ADV_24BIT: assert property (
		req.valid && adv |=> ans.addr == $past(req.addr))
	else $error("advanced mode address not passed whole");

	AST_SMALL_ROM: assert property (
		req.valid && adv && variant_s == MMD_VAR_SMALL &&
			req.addr > MMD_ROM_64K_END |=> !ans.sel.rom)
	else $error("small variant rom beyond 64 kbytes");

	AST_NORM_CAP: assert property (
		req.valid && normal && req.addr[15:0] > MMD_ROM_NORM_END
			|=> !ans.sel.rom)
	else $error("normal mode rom beyond 56 kbytes");

	AST_AREA: assert property (
		req.valid && area_mode |=> ans.area_valid &&
			ans.area == $past(req.addr[23:21]))
	else $error("area number wrong");

	AST_LARGE_EXT: assert property (
		req.valid && adv && rom_on && variant_s == MMD_VAR_LARGE &&
			req.addr > MMD_ROM_64K_END && req.addr <= MMD_ROM_128K_END
			|=> ans.sel.rom == !$past(rom_extension_select) &&
			ans.sel.rsv == $past(rom_extension_select))
	else $error("large variant upper rom decode wrong");

	AST_MID_EXT: assert property (
		req.valid && adv && rom_on && !single && variant_s == MMD_VAR_MID &&
			req.addr > MMD_ROM_64K_END && req.addr <= MMD_ROM_96K_END
			|=> ans.sel.ext == $past(rom_extension_select) &&
			ans.sel.rom == !$past(rom_extension_select))
	else $error("middle variant upper rom decode wrong");

	AST_MID_ABOVE: assert property (
		req.valid && adv && rom_on && !single && variant_s == MMD_VAR_MID &&
			req.addr > MMD_ROM_96K_END && req.addr <= MMD_ROM_128K_END
			|=> ans.sel.ext == $past(rom_extension_select) &&
			ans.sel.rsv == !$past(rom_extension_select))
	else $error("area above middle rom decode wrong");

	AST_RAM_OFF: assert property (
		req.valid && (normal || adv) && !single && !ram_enable_bit && top &&
			lo >= MMD_RAM_BASE && lo < MMD_EXT_MID_BASE
			|=> ans.sel.ext && !ans.sel.ram)
	else $error("disabled ram not sent external");

	AST_SINGLE: assert property (
		single ##1 single [*2] |-> !ans.sel.ext)
	else $error("single-chip mode selected external space");

	AST_MODE1: assert property (
		mode_s == MMD_MODE_1 |=> bus8_mode && !ans.sel.rom)
	else $error("mode one rom or bus width wrong");

	AST_MAP2: assert property (
		req.valid && mode_s == MMD_MODE_2 && req.addr[15:0] == 16'he000
			|=> ans.sel.ext ##1 1'b1)
	else $error("mode two map wrong");

	AST_ONEHOT: assert property (
		ans.valid |-> $onehot(ans.sel))
	else $error("select not exactly one");

	AST_NORM_ROM: assert property (
		req.valid && normal && rom_on && variant_s != MMD_VAR_SPARE &&
			req.addr[15:0] <= MMD_ROM_NORM_END |=> ans.sel.rom)
	else $error("normal mode rom range not decoded as rom");

	AST_RAM_ON: assert property (
		req.valid && (normal || adv) && ram_enable_bit && top &&
			lo >= MMD_RAM_BASE && lo < MMD_EXT_MID_BASE |=> ans.sel.ram)
	else $error("enabled ram range not decoded as ram");
endmodule : mmd_map_decoder

/* File: dv/mmd_core_model.sv */
`timescale 1ns/1ps
module mmd_core_model
	import mmd_pkg::*;
(
	input wire logic ref_clk,
	output mmd_pkg::mmd_req_s req,
	input wire mmd_pkg::mmd_ans_s ans
);
	initial req = '0;
	// one access per call; idle address inverted so stale values never match
	task automatic access(input logic [23:0] a, output mmd_ans_s got);
		@(negedge ref_clk);
		req <= '{valid: 1'b1, addr: a};
		@(negedge ref_clk);
		req <= '{valid: 1'b0, addr: ~a};
		got = ans;
	endtask : access
endmodule : mmd_core_model

/* File: dv/mmd_map_decoder_tb.sv */
`timescale 1ns/1ps
module mmd_map_decoder_tb;
	import mmd_pkg::*;
	localparam logic [4:0] S_ROM = 5'h10;
	localparam logic [4:0] S_RAM = 5'h08;
	localparam logic [4:0] S_IO = 5'h04;
	localparam logic [4:0] S_EXT = 5'h02;
	localparam logic [4:0] S_RSV = 5'h01;
	logic ref_clk;
	logic rstn;
	logic [3:0] mode_pin;
	logic [1:0] variant_pin;
	logic ext_bit;
	logic ram_bit;
	mmd_req_s req;
	mmd_ans_s ans;
	mmd_ans_s last;
	logic bus8;
	logic bad;
	int n_fail;
	int compares;
	logic [15:0] map_a [11] = '{16'h0000, 16'hdfff, 16'he000, 16'hec00,
		16'hf400, 16'hfbff, 16'hfc00, 16'hfe40, 16'hff08, 16'hff28, 16'hffff};
	logic [4:0] map_s [11] = '{S_ROM, S_ROM, S_EXT, S_RSV, S_RAM, S_RAM,
		S_EXT, S_IO, S_EXT, S_IO, S_IO};

	mmd_map_decoder DUT (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.mode_pin(mode_pin),
		.variant_pin(variant_pin),
		.req(req),
		.rom_extension_select(ext_bit),
		.ram_enable_bit(ram_bit),
		.ans(ans),
		.bus8_mode(bus8),
		.mode_bad(bad)
	);
	mmd_core_model core (
		.ref_clk(ref_clk),
		.req(req),
		.ans(ans)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic give_verdict();
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [23:0] e,
		input logic [23:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// straps pass two sync flops, so settle three cycles
	task automatic cfg(input logic [3:0] m, input logic [1:0] v,
		input logic e, input logic r);
		@(negedge ref_clk);
		mode_pin = m;
		variant_pin = v;
		ext_bit = e;
		ram_bit = r;
		repeat (3) @(negedge ref_clk);
	endtask : cfg

	task automatic probe(input logic [23:0] a, input logic [4:0] s);
		core.access(a, last);
		chk("valid", 24'h1, {23'h0, last.valid});
		chk("sel", {19'h0, s}, {19'h0, last.sel});
	endtask : probe

	task automatic t_normal();
		cfg(MMD_MODE_2, MMD_VAR_SMALL, 1'b0, 1'b1);
		for (int i = 0; i < 11; i++) begin
			probe({8'h0, map_a[i]}, map_s[i]);
		end
		probe(24'hab0010, S_ROM);
		chk("addr", 24'h000010, last.addr);
		@(negedge ref_clk);
		chk("idle_valid", 24'h0, {23'h0, ans.valid});
		chk("idle_sel", 24'h0, {19'h0, ans.sel});
		chk("bus8", 24'h1, {23'h0, bus8});
		ram_bit = 1'b0;
		probe(24'h00f400, S_EXT);
		cfg(MMD_MODE_2, MMD_VAR_LARGE, 1'b0, 1'b1);
		probe(24'h00e000, S_EXT);
		probe(24'h00dfff, S_ROM);
	endtask : t_normal

	task automatic t_single();
		cfg(MMD_MODE_3, MMD_VAR_SMALL, 1'b0, 1'b1);
		probe(24'h00e000, S_RSV);
		probe(24'h00ff08, S_RSV);
		probe(24'h000000, S_ROM);
		cfg(MMD_MODE_7, MMD_VAR_LARGE, 1'b1, 1'b1);
		probe(24'h100000, S_RSV);
		probe(24'h010000, S_RSV);
		ext_bit = 1'b0;
		probe(24'h01ffff, S_ROM);
		cfg(MMD_MODE_1, MMD_VAR_SMALL, 1'b0, 1'b1);
		probe(24'h000000, S_EXT);
		probe(24'h00ebff, S_EXT);
	endtask : t_single

	task automatic t_adv();
		cfg(MMD_MODE_6, MMD_VAR_MID, 1'b1, 1'b1);
		probe(24'h010000, S_EXT);
		probe(24'h018000, S_EXT);
		ext_bit = 1'b0;
		probe(24'h017fff, S_ROM);
		probe(24'h018000, S_RSV);
		probe(24'hfffe40, S_IO);
		chk("addr", 24'hfffe40, last.addr);
		chk("bus8", 24'h0, {23'h0, bus8});
		probe(24'h00fe40, S_ROM);
		cfg(MMD_MODE_6, MMD_VAR_SMALL, 1'b0, 1'b1);
		probe(24'h010000, S_EXT);
	endtask : t_adv

	// every mode code, legal or not, for area report and bad flag
	task automatic t_modes();
		logic av;
		logic ok;
		logic nm;
		for (int m = 0; m < 16; m++) begin
			av = m inside {4, 5, 6, 10, 14};
			ok = m inside {[1:7], 10, 11, 14, 15};
			// area field always carries the top bits; normal modes cut them
			nm = m inside {[1:3]};
			cfg(m[3:0], MMD_VAR_SMALL, 1'b0, 1'b1);
			core.access(24'ha00000, last);
			chk("area_valid", {23'h0, av}, {23'h0, last.area_valid});
			chk("area", nm ? 24'h0 : 24'h5, {21'h0, last.area});
			chk("mode_bad", {23'h0, !ok}, {23'h0, bad});
			if (!ok) begin
				chk("sel", {19'h0, S_RSV}, {19'h0, last.sel});
			end
		end
	endtask : t_modes

	// mid-run reset: outputs clear, straps read as mode zero for two edges
	task automatic t_reset();
		cfg(MMD_MODE_1, MMD_VAR_SMALL, 1'b0, 1'b1);
		chk("bus8", 24'h1, {23'h0, bus8});
		rstn = 1'b0;
		@(negedge ref_clk);
		chk("rst_valid", 24'h0, {23'h0, ans.valid});
		chk("rst_bus8", 24'h0, {23'h0, bus8});
		chk("rst_bad", 24'h0, {23'h0, bad});
		rstn = 1'b1;
		@(negedge ref_clk);
		chk("bad_after_rst", 24'h1, {23'h0, bad});
		repeat (2) @(negedge ref_clk);
		chk("bad_settled", 24'h0, {23'h0, bad});
		core.access(24'h001234, last);
		chk("sel", {19'h0, S_EXT}, {19'h0, last.sel});
		chk("bus8", 24'h1, {23'h0, bus8});
	endtask : t_reset

	initial begin
		n_fail = 0;
		compares = 0;
		rstn = 1'b0;
		mode_pin = MMD_MODE_2;
		variant_pin = MMD_VAR_SMALL;
		ext_bit = 1'b0;
		ram_bit = 1'b1;
		repeat (6) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (3) @(negedge ref_clk);
		t_normal();
		t_single();
		t_adv();
		t_modes();
		t_reset();
		give_verdict();
	end

	// whole run is a few hundred cycles
	initial begin
		#40000;
		n_fail++;
		give_verdict();
	end
endmodule : mmd_map_decoder_tb
